// ---- logic/hcac_params.svh ----
// Purpose: Constants for hub configuration and attach control
// Assumes: 32-bit AHB-Lite register words, byte addresses
// Notes:   Offsets, fields, reset values and timing counts
`ifndef HCAC_PARAMS_SVH
`define HCAC_PARAMS_SVH

// Register byte offsets
`define HCAC_OFF_CFG      8'h00
`define HCAC_OFF_CTRL     8'h04
`define HCAC_OFF_STATUS   8'h08

// Configuration word fields
`define HCAC_CFG_HS       0
`define HCAC_CFG_SELF     1
`define HCAC_CFG_DYN      2
`define HCAC_CFG_FIX_LO   3
`define HCAC_CFG_FIX_HI   4
`define HCAC_CFG_LEDP_LO  5
`define HCAC_CFG_LEDP_HI  6
`define HCAC_CFG_LEDEN    7
`define HCAC_CFG_W        8

// Built-in default configuration: high speed, self powered, LED enable bit clear
`define HCAC_CFG_DEFAULT  8'h03

// Control fields
`define HCAC_CTRL_PWR     0
`define HCAC_CTRL_GO      1

// Status fields
`define HCAC_ST_LOADED    0
`define HCAC_ST_ATTACH    1
`define HCAC_ST_SELFP     2
`define HCAC_ST_OC        3
`define HCAC_ST_UPWR      4
`define HCAC_ST_POL       5
`define HCAC_ST_EEABS     6
`define HCAC_ST_SRC_LO    8
`define HCAC_ST_SRC_HI    9

// Strap settle cycles after reset release (synchroniser depth)
`define HCAC_SETTLE       2'h2
`define HCAC_HTRANS_NONSEQ 2'h2

`endif

// ---- logic/hcac_pkg.sv ----
// Purpose: Types for hub configuration and attach control
// Assumes: Included params header holds all numbers
// Notes:   Source codes follow the two-bit selection strap
package hcac_pkg;
    typedef enum logic [1:0] {
        HCAC_SRC_DEFAULT,
        HCAC_SRC_EEPROM,
        HCAC_SRC_SMBUS,
        HCAC_SRC_DEFAULT_ALT
    } hcac_src_t;

    typedef enum logic {
        HCAC_SPEED_FULL,
        HCAC_SPEED_HIGH
    } hcac_speed_t;
endpackage

// ---- logic/hcac_top.sv ----
// Purpose: Configuration source choice, strap capture and attach control of a 2-port hub
// Assumes: hclk 50 MHz; straps and sense pins are asynchronous and are synchronised here
// Notes:   Registers over AHB-Lite, zero wait states, always OKAY
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "hcac_params.svh"

module hcac_top (
    input  wire logic                  hclk,                      // 50 MHz clock
    input  wire logic                  hresetn,                   // Async reset, low
    input  wire logic                  hsel,                      // Slave select
    input  wire logic [31:0]           haddr,                     // Byte address
    input  wire logic [1:0]            htrans,                    // Transfer type
    input  wire logic                  hwrite,                    // Write when high
    input  wire logic [2:0]            hsize,                     // Word only
    input  wire logic [31:0]           hwdata,                    // Write data
    input  wire logic                  hready,                    // Bus ready
    output logic                       hreadyout,                 // Always ready
    output logic                       hresp,                     // Always OKAY
    output logic [31:0]                hrdata,                    // Read data
    input  wire logic [1:0]            cfg_sel_strap,             // Source strap pins
    input  wire logic [1:0]            fixed_port_strap,          // Strap side of LED pins
    output logic [1:0]                 port_led_o,                // LED pin drive
    output logic [1:0]                 port_led_oe,               // LED pin enable
    input  wire logic [1:0]            port_led_on,               // LED request, same clock
    input  wire logic                  port_power_polarity_strap, // Polarity strap pin
    output logic                       port_power_enable,         // To power switch
    input  wire logic                  overcurrent_sense_n,       // Switch fault, low
    input  wire logic                  upstream_power_sense,      // Upstream VBUS sense
    input  wire logic                  local_supply_sense,        // Local supply present
    output logic                       dp_pullup_en,              // Connect pull-up
    output hcac_pkg::hcac_speed_t      hub_speed,                 // Reported hub speed
    output logic                       hs_downstream_en,          // High speed allowed
    output logic                       self_powered,              // Power mode shown
    output logic [1:0]                 fixed_ports,               // Non-removable ports
    output logic                       ee_start,                  // Start EEPROM read
    input  wire logic                  ee_word_valid,             // EEPROM word ready
    input  wire logic [7:0]            ee_word,                   // EEPROM config byte
    input  wire logic                  ee_nack                    // No EEPROM answered
);
    import hcac_pkg::*;

    typedef enum logic [2:0] {
        HCAC_ST_SETTLE,
        HCAC_ST_PICK,
        HCAC_ST_EE,
        HCAC_ST_SMB,
        HCAC_ST_RUN
    } hcac_state_t;

    // Apply an active level to a logical on/off
    function automatic logic hcac_drive(input logic on, input logic act_high);
        hcac_drive = act_high ? on : ~on;
    endfunction

    hcac_state_t                 state_ff, nxt_state;
    logic [1:0]                  settle_ff;
    logic [1:0]                  sel_m_ff, sel_s_ff;
    logic [1:0]                  fix_m_ff, fix_s_ff;
    logic                        pol_m_ff, pol_s_ff;
    logic [2:0]                  sns_m_ff, sns_s_ff;
    hcac_src_t                   src_ff;
    logic                        pol_ff;
    logic                        pol_valid_ff;
    logic [`HCAC_CFG_W-1:0]      cfg_ff;
    logic [1:0]                  ctrl_ff;
    logic                        oc_ff;
    logic                        eeabs_ff;
    logic                        ee_start_ff;
    logic                        wr_pend_ff;
    logic [7:0]                  wr_addr_ff;
    logic [31:0]                 rdata_ff;
    logic                        addr_ok;
    logic                        loaded;
    logic                        up_power;
    logic                        local_pwr;
    logic                        oc_now;
    logic                        wr_cfg;
    logic                        wr_ctrl;
    logic                        wr_stat;
    logic [31:0]                 status_w;

    // Two-flop synchronisers for every pin input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_m_ff <= 2'h0;
            sel_s_ff <= 2'h0;
            fix_m_ff <= 2'h0;
            fix_s_ff <= 2'h0;
            pol_m_ff <= 1'h0;
            pol_s_ff <= 1'h0;
            sns_m_ff <= 3'h0;
            sns_s_ff <= 3'h0;
        end else begin
            sel_m_ff <= cfg_sel_strap;
            sel_s_ff <= sel_m_ff;
            fix_m_ff <= fixed_port_strap;
            fix_s_ff <= fix_m_ff;
            pol_m_ff <= port_power_polarity_strap;
            pol_s_ff <= pol_m_ff;
            sns_m_ff <= {~overcurrent_sense_n, local_supply_sense, upstream_power_sense};
            sns_s_ff <= sns_m_ff;
        end
    end

    assign up_power  = sns_s_ff[0];
    assign local_pwr = sns_s_ff[1];
    assign oc_now    = sns_s_ff[2];
    assign loaded    = (state_ff == HCAC_ST_RUN);

    // Bus decode; writes land in the data phase
    assign addr_ok = hsel & hready & (htrans == `HCAC_HTRANS_NONSEQ);
    assign wr_cfg  = wr_pend_ff & (wr_addr_ff == `HCAC_OFF_CFG);
    assign wr_ctrl = wr_pend_ff & (wr_addr_ff == `HCAC_OFF_CTRL);
    assign wr_stat = wr_pend_ff & (wr_addr_ff == `HCAC_OFF_STATUS);

    // Settle counter lets synchronised straps reach their final value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_ff <= 2'h0;
        end else if (state_ff == HCAC_ST_SETTLE) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    // Sequencer: pick source once, load, then allow attach
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            HCAC_ST_SETTLE: begin
                if (settle_ff == `HCAC_SETTLE) begin
                    nxt_state = HCAC_ST_PICK;
                end
            end
            HCAC_ST_PICK: begin
                case (src_ff)
                    HCAC_SRC_EEPROM: nxt_state = HCAC_ST_EE;
                    HCAC_SRC_SMBUS:  nxt_state = HCAC_ST_SMB;
                    default:         nxt_state = HCAC_ST_RUN;
                endcase
            end
            HCAC_ST_EE: begin
                if (ee_nack || ee_word_valid) begin
                    nxt_state = HCAC_ST_RUN;
                end
            end
            HCAC_ST_SMB: begin
                if (wr_ctrl && hwdata[`HCAC_CTRL_GO]) begin
                    nxt_state = HCAC_ST_RUN;
                end
            end
            HCAC_ST_RUN: nxt_state = HCAC_ST_RUN;
            default:     nxt_state = HCAC_ST_SETTLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= HCAC_ST_SETTLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Source and polarity straps caught once, after the settle time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_ff       <= HCAC_SRC_DEFAULT;
            pol_ff       <= 1'h0;
            pol_valid_ff <= 1'h0;
        end else if (state_ff == HCAC_ST_SETTLE && settle_ff == `HCAC_SETTLE) begin
            src_ff       <= hcac_src_t'(sel_s_ff);
            pol_ff       <= pol_s_ff;
            pol_valid_ff <= 1'h1;
        end
    end

    // Configuration word: default plus straps, EEPROM byte, zero fill or software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_ff   <= `HCAC_CFG_DEFAULT;
            eeabs_ff <= 1'h0;
        end else begin
            case (state_ff)
                HCAC_ST_PICK: begin
                    if (src_ff == HCAC_SRC_DEFAULT || src_ff == HCAC_SRC_DEFAULT_ALT) begin
                        // Strap code 01 fixes port 1; 10 and 11 fix both
                        cfg_ff[`HCAC_CFG_FIX_LO] <= fix_s_ff[1] | fix_s_ff[0];
                        cfg_ff[`HCAC_CFG_FIX_HI] <= fix_s_ff[1];
                        cfg_ff[`HCAC_CFG_LEDP_HI:`HCAC_CFG_LEDP_LO] <= fix_s_ff;
                    end
                end
                HCAC_ST_EE: begin
                    if (ee_nack) begin
                        cfg_ff   <= {`HCAC_CFG_W{1'b0}};
                        eeabs_ff <= 1'h1;
                    end else if (ee_word_valid) begin
                        cfg_ff <= ee_word;
                    end
                end
                HCAC_ST_SMB: begin
                    if (wr_cfg) begin
                        cfg_ff <= hwdata[`HCAC_CFG_W-1:0];
                    end
                end
                default: cfg_ff <= cfg_ff;
            endcase
        end
    end

    // One-cycle request to the EEPROM reader
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ee_start_ff <= 1'h0;
        end else begin
            ee_start_ff <= (state_ff == HCAC_ST_PICK) && (src_ff == HCAC_SRC_EEPROM);
        end
    end
    assign ee_start = ee_start_ff;

    // Control: port power request, attach go (self-clearing)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= 2'h0;
        end else if (wr_ctrl) begin
            ctrl_ff <= {1'b0, hwdata[`HCAC_CTRL_PWR]};
        end
    end

    // Sticky fault; a new fault beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_ff <= 1'h0;
        end else begin
            oc_ff <= oc_now | (oc_ff & ~(wr_stat & hwdata[`HCAC_ST_OC]));
        end
    end

    // Bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'h0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // Status word
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`HCAC_ST_LOADED] = loaded;
        status_w[`HCAC_ST_ATTACH] = dp_pullup_en;
        status_w[`HCAC_ST_SELFP]  = self_powered;
        status_w[`HCAC_ST_OC]     = oc_ff;
        status_w[`HCAC_ST_UPWR]   = up_power;
        status_w[`HCAC_ST_POL]    = pol_ff;
        status_w[`HCAC_ST_EEABS]  = eeabs_ff;
        status_w[`HCAC_ST_SRC_HI:`HCAC_ST_SRC_LO] = src_ff;
    end

    // Read data sampled in the address phase; a write just before is not seen yet
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                `HCAC_OFF_CFG:    rdata_ff <= {24'h00_0000, cfg_ff};
                `HCAC_OFF_CTRL:   rdata_ff <= {30'h0000_0000, ctrl_ff};
                `HCAC_OFF_STATUS: rdata_ff <= status_w;
                default:          rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Hub mode outputs; speed and fixed ports valid only once loaded, self_powered always
    assign hub_speed        = (loaded && cfg_ff[`HCAC_CFG_HS]) ? HCAC_SPEED_HIGH
                                                               : HCAC_SPEED_FULL;
    assign hs_downstream_en = (hub_speed == HCAC_SPEED_HIGH);
    assign fixed_ports      = loaded ? cfg_ff[`HCAC_CFG_FIX_HI:`HCAC_CFG_FIX_LO] : 2'h0;
    assign self_powered     = cfg_ff[`HCAC_CFG_DYN] ? local_pwr
                                                    : cfg_ff[`HCAC_CFG_SELF];

    // Connect only when loaded and upstream power is present
    assign dp_pullup_en = loaded & up_power;

    // Port power: inverted strap level straight through until latched, so reset keeps ports off
    assign port_power_enable = pol_valid_ff
        ? hcac_drive(loaded & ctrl_ff[`HCAC_CTRL_PWR] & ~oc_now, pol_ff)
        : ~port_power_polarity_strap;

    // LED pins stay released until loaded, then drive in a default source mode or when the LED enable bit is set
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            port_led_o[i]  = hcac_drive(port_led_on[i], ~cfg_ff[`HCAC_CFG_LEDP_LO + i]);
            port_led_oe[i] = loaded &
                (cfg_ff[`HCAC_CFG_LEDEN] | (src_ff == HCAC_SRC_DEFAULT) |
                 (src_ff == HCAC_SRC_DEFAULT_ALT));
        end
    end
endmodule

// ---- dv/hcac_top_assertions.sv ----
// Purpose: Port-level timing checks for hub configuration and attach
// Assumes: Straps stay put across reset release
// Notes:   Bound to hcac_top; helper logic only counts and latches
`timescale 1ns/100ps
module hcac_top_assertions
    import hcac_pkg::*;
(
    input wire logic                  hclk,                      // Clock
    input wire logic                  hresetn,                   // Async reset, low
    input wire logic                  hreadyout,                 // Bus ready
    input wire logic                  hresp,                     // Bus response
    input wire logic                  port_power_polarity_strap, // Polarity strap
    input wire logic                  port_power_enable,         // Power switch drive
    input wire logic                  overcurrent_sense_n,       // Switch fault, low
    input wire logic                  upstream_power_sense,      // Upstream power
    input wire logic                  dp_pullup_en,              // Connect pull-up
    input wire hcac_pkg::hcac_speed_t hub_speed,                 // Reported speed
    input wire logic                  hs_downstream_en,          // High speed allowed
    input wire logic [1:0]            fixed_ports,               // Fixed ports
    input wire logic                  ee_start                   // EEPROM read start
);
    logic       pol_ff;    // Polarity seen at release
    logic       seen_ff;   // First edge after release passed
    logic [1:0] ee_cnt_ff; // Read starts since reset

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Capture polarity once; later strap moves must not matter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_ff <= 1'b0;
            pol_ff  <= 1'b0;
        end else if (!seen_ff) begin
            seen_ff <= 1'b1;
            pol_ff  <= port_power_polarity_strap;
        end
    end

    // Saturating count of EEPROM read starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ee_cnt_ff <= 2'h0;
        end else if (ee_start && ee_cnt_ff != 2'h3) begin
            ee_cnt_ff <= ee_cnt_ff + 2'h1;
        end
    end

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    hs_follow_a: assert property (hs_downstream_en == (hub_speed == HCAC_SPEED_HIGH))
        else $error("high speed downstream disagrees with hub speed");
    pullup_rise_a: assert property ($rose(dp_pullup_en) |-> $past(upstream_power_sense, 2))
        else $error("pull-up rose without upstream power");
    pullup_drop_a: assert property (!upstream_power_sense [*3] |=> !dp_pullup_en)
        else $error("pull-up on with no upstream power");
    attach_after_a: assert property (ee_start |-> !dp_pullup_en)
        else $error("attached before configuration load");
    read_once_a: assert property (ee_start |-> ee_cnt_ff == 2'h0)
        else $error("second EEPROM read in one reset");
    idle_power_a: assert property (ee_start |-> port_power_enable == !pol_ff)
        else $error("port power active before load");
    oc_cut_a: assert property (!overcurrent_sense_n [*3] |=> port_power_enable == !pol_ff)
        else $error("port power kept on during overcurrent");
    speed_hold_a: assert property ($changed(hub_speed) |-> !$past(dp_pullup_en))
        else $error("hub speed changed while attached");
    fixed_hold_a: assert property ($changed(fixed_ports) |-> !$past(dp_pullup_en))
        else $error("fixed ports changed while attached");

    cover property ($rose(dp_pullup_en));
    cover property (ee_start);
    cover property (!overcurrent_sense_n && hub_speed == HCAC_SPEED_HIGH);
endmodule

bind hcac_top hcac_top_assertions u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .port_power_polarity_strap(port_power_polarity_strap),
    .port_power_enable(port_power_enable), .overcurrent_sense_n(overcurrent_sense_n),
    .upstream_power_sense(upstream_power_sense), .dp_pullup_en(dp_pullup_en),
    .hub_speed(hub_speed), .hs_downstream_en(hs_downstream_en),
    .fixed_ports(fixed_ports), .ee_start(ee_start)
);

// ---- dv/hcac_eeprom_model.sv ----
// Purpose: Serial configuration memory seen from the load port
// Assumes: One config byte per read, answer after a set delay
// Notes:   Absent memory answers with a no-response pulse
`timescale 1ns/100ps
module hcac_eeprom_model (
    input  wire logic       hclk,          // Clock
    input  wire logic       hresetn,       // Async reset, low
    input  wire logic       ee_start,      // Read request
    input  wire logic       ee_present,    // Memory fitted
    input  wire logic [3:0] ee_delay,      // Answer delay in cycles
    input  wire logic [7:0] ee_data,       // Stored config byte
    output logic            ee_word_valid, // Byte ready pulse
    output logic [7:0]      ee_word,       // Byte
    output logic            ee_nack        // Nobody answered
);
    logic       busy_ff; // Read in flight
    logic [3:0] cnt_ff;  // Cycles left

    // Data lines toggle outside the valid pulse so stale values never pass
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_ff       <= 1'b0;
            cnt_ff        <= 4'h0;
            ee_word_valid <= 1'b0;
            ee_nack       <= 1'b0;
            ee_word       <= 8'h00;
        end else begin
            ee_word_valid <= 1'b0;
            ee_nack       <= 1'b0;
            ee_word       <= ~ee_word;
            if (ee_start) begin
                busy_ff <= 1'b1;
                cnt_ff  <= ee_delay;
            end else if (busy_ff && cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end else if (busy_ff) begin
                busy_ff       <= 1'b0;
                ee_word_valid <= ee_present;
                ee_nack       <= !ee_present;
                ee_word       <= ee_present ? ee_data : ~ee_word;
            end
        end
    end
endmodule

// ---- dv/hub_config_attach_control_test.sv ----
// Purpose: Directed bench for hub configuration and attach control
// Assumes: Zero-wait register slave, EEPROM model on the load port
// Notes:   Four resets: default, absent EEPROM, EEPROM, controller load
`timescale 1ns/100ps
`include "hcac_params.svh"
module hub_config_attach_control_test;
    import hcac_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ee_present;
    logic        port_power_polarity_strap, port_power_enable, overcurrent_sense_n;
    logic        upstream_power_sense, local_supply_sense, dp_pullup_en, hs_downstream_en;
    logic        self_powered, ee_start, ee_word_valid, ee_nack;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, cfg_sel_strap, fixed_port_strap, port_led_o, port_led_oe;
    logic [1:0]  port_led_on, fixed_ports;
    logic [2:0]  hsize;
    logic [3:0]  ee_delay;
    logic [7:0]  ee_word, ee_data;
    hcac_speed_t hub_speed;
    int          bad_count, check_count;

    hcac_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cfg_sel_strap, .fixed_port_strap,
        .port_led_o, .port_led_oe, .port_led_on, .port_power_polarity_strap,
        .port_power_enable, .overcurrent_sense_n, .upstream_power_sense, .local_supply_sense,
        .dp_pullup_en, .hub_speed, .hs_downstream_en, .self_powered, .fixed_ports, .ee_start,
        .ee_word_valid, .ee_word, .ee_nack);
    hcac_eeprom_model u_ee (.hclk, .hresetn, .ee_start, .ee_present, .ee_delay, .ee_data,
        .ee_word_valid, .ee_word, .ee_nack);

    // 50 MHz clock
    initial hclk = 1'b0;
    always #10 hclk = ~hclk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bit1(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    // One single transfer; hold each phase until ready is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= `HCAC_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(nm, x, e);
    endtask
    // Poll the loaded flag, bounded so a stuck load shows as a mismatch
    task automatic wait_loaded();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 40 && s[0] !== 1'b1; i++) bus(1'b0, `HCAC_OFF_STATUS, 32'h0, s);
        bit1("loaded", s[0], 1'b1);
    endtask
    task automatic rst(input logic [1:0] sel, input logic [1:0] fix, input logic pol);
        @(posedge hclk);
        hresetn <= 1'b0;
        cfg_sel_strap <= sel;
        fixed_port_strap <= fix;
        port_power_polarity_strap <= pol;
        repeat (8) @(posedge hclk);
        @(negedge hclk);
        bit1("enable_in_reset", port_power_enable, !pol);
        @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task automatic close_out();
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        bad_count++;
        close_out();
    end

    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize} = {3'b010, 66'h0, 3'h2};
        {upstream_power_sense, local_supply_sense, ee_present} = 3'b000;
        {overcurrent_sense_n, port_led_on, ee_delay, ee_data} = {3'b100, 4'h3, 8'h87};
        {cfg_sel_strap, fixed_port_strap, port_power_polarity_strap} = 5'b00011;
        rst(2'b00, 2'b01, 1'b1);
        wait_loaded();
        rdc("cfg_default", `HCAC_OFF_CFG, 32'h2B);
        @(negedge hclk);
        bit1("speed_high", hub_speed, HCAC_SPEED_HIGH);
        bit1("hs_down_on", hs_downstream_en, 1'b1);
        check("fixed_01", {30'h0, fixed_ports}, 32'h1);
        bit1("pullup_no_power", dp_pullup_en, 1'b0);
        @(posedge hclk);
        {upstream_power_sense, port_led_on, port_power_polarity_strap} <= 4'b1110;
        fixed_port_strap <= 2'b11;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        bit1("pullup_power", dp_pullup_en, 1'b1);
        check("led_drive", {30'h0, port_led_o}, 32'h2);
        check("led_enable", {30'h0, port_led_oe}, 32'h3);
        check("fixed_kept", {30'h0, fixed_ports}, 32'h1);
        wr(`HCAC_OFF_CTRL, 32'h1);
        @(negedge hclk);
        bit1("power_high", port_power_enable, 1'b1);
        @(posedge hclk);
        overcurrent_sense_n <= 1'b0;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        bit1("power_cut", port_power_enable, 1'b0);
        rdc("status_oc", `HCAC_OFF_STATUS, 32'h3F);
        overcurrent_sense_n <= 1'b1;
        repeat (3) @(posedge hclk);
        wr(`HCAC_OFF_STATUS, 32'h8);
        rdc("status_clear", `HCAC_OFF_STATUS, 32'h37);
        wr(`HCAC_OFF_CFG, 32'h0);
        rdc("cfg_locked", `HCAC_OFF_CFG, 32'h2B);
        rdc("unmapped", 8'h0C, 32'h0);
        // Absent EEPROM, active-low power
        rst(2'b01, 2'b00, 1'b0);
        wait_loaded();
        rdc("cfg_zero", `HCAC_OFF_CFG, 32'h0);
        rdc("status_absent", `HCAC_OFF_STATUS, 32'h153);
        @(negedge hclk);
        bit1("speed_full", hub_speed, HCAC_SPEED_FULL);
        bit1("hs_down_off", hs_downstream_en, 1'b0);
        bit1("bus_powered", self_powered, 1'b0);
        bit1("attach_zero", dp_pullup_en, 1'b1);
        check("led_off_ee", {30'h0, port_led_oe}, 32'h0);
        wr(`HCAC_OFF_CTRL, 32'h1);
        @(negedge hclk);
        bit1("power_low", port_power_enable, 1'b0);
        // Slow EEPROM with dynamic power
        @(posedge hclk);
        {ee_present, ee_delay} <= 5'h19;
        rst(2'b01, 2'b00, 1'b1);
        wait_loaded();
        rdc("cfg_eeprom", `HCAC_OFF_CFG, 32'h87);
        @(negedge hclk);
        bit1("dyn_no_local", self_powered, 1'b0);
        check("led_on_ee", {30'h0, port_led_oe}, 32'h3);
        @(posedge hclk);
        local_supply_sense <= 1'b1;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        bit1("dyn_local", self_powered, 1'b1);
        // Controller load: no attach until GO
        rst(2'b10, 2'b00, 1'b1);
        repeat (12) @(posedge hclk);
        @(negedge hclk);
        bit1("held_off", dp_pullup_en, 1'b0);
        wr(`HCAC_OFF_CFG, 32'h4);
        wr(`HCAC_OFF_CTRL, 32'h2);
        wait_loaded();
        rdc("cfg_ctrl", `HCAC_OFF_CFG, 32'h4);
        @(negedge hclk);
        bit1("ctrl_speed", hub_speed, HCAC_SPEED_FULL);
        bit1("ctrl_self", self_powered, 1'b1);
        @(posedge hclk);
        local_supply_sense <= 1'b0;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        bit1("ctrl_bus", self_powered, 1'b0);
        close_out();
    end
endmodule
